// [rtl/cci_comparator_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [R1] control register is 16 bits; bits 15..11 reserved, read zero
// [R2] bit 10 switches the comparator on when one, off when zero
// [R3] switching the comparator on raises a spurious comparator interrupt
// [R4] bits 9:8 select negative input: half supply, channel three, 0.6 reference
// [R5] bits 7:6: 00/01 nothing, 10 logic fabric only, 11 interrupt only
// [R6] bit 5 inverts the comparator output
// [R7] bits 4:3 select response speed: 00 slow, 11 fast, others reserved
// [R8] bit 2 turns hysteresis on
// [R9] rising edge sets bit 1; writing one clears it
// [R10] falling edge sets bit 0; stays set until software clears it
// [R11] writing one clears bit 0; writing zero leaves either flag alone
// [R12] interrupt while a flag is set and route selects interrupt; edges synchronised
module cci_comparator_ctrl (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [cci_pkg::ADR_W-1:0]    wb_adr_i,
  input  wire logic [cci_pkg::SEL_W-1:0]    wb_sel_i,
  input  wire logic [cci_pkg::DATA_W-1:0]   wb_dat_i,
  output      logic [cci_pkg::DATA_W-1:0]   wb_dat_o,
  output      logic                         wb_ack_o,
  input  wire logic                         comp_raw_i,
  output      logic                         comparator_on_o,
  output      logic [1:0]                   negative_input_select_o,
  output      logic                         output_polarity_o,
  output      logic [1:0]                   response_speed_o,
  output      logic                         hysteresis_on_o,
  output      logic                         comp_out_o,
  output      logic                         fabric_out_o,
  output      logic                         comp_irq_o
);

  cci_bus_if  bus ();
  cci_edge_if edg ();

  // control fields
  logic                            on_r,     on_nxt;
  logic [cci_pkg::FIELD2_W-1:0]    neg_r,    neg_nxt;
  logic [cci_pkg::FIELD2_W-1:0]    route_r,  route_nxt;
  logic                            pol_r,    pol_nxt;
  logic [cci_pkg::FIELD2_W-1:0]    speed_r,  speed_nxt;
  logic                            hyst_r,   hyst_nxt;
  logic                            rise_r,   rise_nxt;
  logic                            fall_r,   fall_nxt;
  logic                            irq_r,    irq_nxt;
  logic                            fabric_r, fabric_nxt;

  // decode and data helpers
  logic                            ctrl_wr;
  logic [cci_pkg::REG_W-1:0]       ctrl_word;
  logic [cci_pkg::REG_W-1:0]       stat_word;
  logic [cci_pkg::REG_W-1:0]       wval;
  logic                            clr_rise;
  logic                            clr_fall;
  logic                            set_rise;
  logic                            set_fall;

  // word-aligned address match, low two bits ignored
  function automatic logic adr_hit(input logic [cci_pkg::ADR_W-1:0] adr,
                                   input logic [cci_pkg::ADR_W-1:0] ofs);
    adr_hit = (adr[cci_pkg::ADR_W-1:2] == ofs[cci_pkg::ADR_W-1:2]);
  endfunction : adr_hit

  // byte-lane merge of a write into the 16-bit register
  function automatic logic [cci_pkg::REG_W-1:0] lane_merge(
    input logic [cci_pkg::REG_W-1:0] old,
    input logic [cci_pkg::REG_W-1:0] wd,
    input logic [1:0]                sel);
    logic [cci_pkg::REG_W-1:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      res[15:8] = wd[15:8];
    end
    lane_merge = res;
  endfunction : lane_merge

  cci_wb_slave u_slave (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .bus      (bus.slv)
  );

  cci_edge_det u_det (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .raw_i (comp_raw_i),
    .edg   (edg.det)
  );

  // detector follows the stored enable and polarity
  assign edg.enable = on_r;
  assign edg.invert = pol_r;

  // assemble the readable control word; reserved bits stay zero
  always_comb begin
    ctrl_word = '0;                                               // see [R1]
    ctrl_word[cci_pkg::BIT_ON]                          = on_r;
    ctrl_word[cci_pkg::NEG_LO +: cci_pkg::FIELD2_W]     = neg_r;
    ctrl_word[cci_pkg::ROUTE_LO +: cci_pkg::FIELD2_W]   = route_r;
    ctrl_word[cci_pkg::BIT_POL]                         = pol_r;
    ctrl_word[cci_pkg::SPEED_LO +: cci_pkg::FIELD2_W]   = speed_r;
    ctrl_word[cci_pkg::BIT_HYST]                        = hyst_r;
    ctrl_word[cci_pkg::BIT_RISE]                        = rise_r;
    ctrl_word[cci_pkg::BIT_FALL]                        = fall_r;
  end

  // status word shows the live conditioned comparator level
  always_comb begin
    stat_word = '0;
    stat_word[cci_pkg::STAT_LEVEL] = edg.level;
  end

  // read mux; unmapped offsets read zero but are still acked
  always_comb begin
    bus.rdata = '0;
    if (adr_hit(bus.adr, cci_pkg::CTRL_OFS)) begin
      bus.rdata[cci_pkg::REG_W-1:0] = ctrl_word;
    end else if (adr_hit(bus.adr, cci_pkg::STAT_OFS)) begin
      bus.rdata[cci_pkg::REG_W-1:0] = stat_word;
    end
  end

  // write decode; high half-word lanes hit nothing
  assign ctrl_wr = bus.wr_stb & adr_hit(bus.adr, cci_pkg::CTRL_OFS);
  assign wval    = lane_merge(ctrl_word, bus.wdata[cci_pkg::REG_W-1:0], bus.sel[1:0]);

  // plain read/write fields; reserved codes are stored as written
  always_comb begin
    on_nxt    = on_r;
    neg_nxt   = neg_r;
    route_nxt = route_r;
    pol_nxt   = pol_r;
    speed_nxt = speed_r;
    hyst_nxt  = hyst_r;
    if (ctrl_wr) begin
      on_nxt    = wval[cci_pkg::BIT_ON];                          // see [R2]
      neg_nxt   = wval[cci_pkg::NEG_LO +: cci_pkg::FIELD2_W];     // see [R4]
      route_nxt = wval[cci_pkg::ROUTE_LO +: cci_pkg::FIELD2_W];   // see [R5]
      pol_nxt   = wval[cci_pkg::BIT_POL];                         // see [R6]
      speed_nxt = wval[cci_pkg::SPEED_LO +: cci_pkg::FIELD2_W];   // see [R7]
      hyst_nxt  = wval[cci_pkg::BIT_HYST];                        // see [R8]
    end
  end

  // write-one-to-clear flags; a set in the same cycle beats the clear
  always_comb begin
    clr_rise = ctrl_wr & bus.sel[0] & bus.wdata[cci_pkg::BIT_RISE];  // see [R9]
    clr_fall = ctrl_wr & bus.sel[0] & bus.wdata[cci_pkg::BIT_FALL];  // see [R11]
    // turning on raises the rising flag as the spurious interrupt
    set_rise = edg.rise | (on_nxt & ~on_r);                          // see [R3]
    set_fall = edg.fall;                                             // see [R10]
    rise_nxt = set_rise | (rise_r & ~clr_rise);                      // see [R9]
    fall_nxt = set_fall | (fall_r & ~clr_fall);                      // see [R10] [R11]
  end

  // routed outputs, registered so they come straight from flops
  always_comb begin
    irq_nxt    = (rise_nxt | fall_nxt) & (route_nxt == cci_pkg::ROUTE_IRQ);  // see [R12]
    fabric_nxt = edg.level & (route_nxt == cci_pkg::ROUTE_FABRIC);          // see [R5]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_r     <= cci_pkg::CTRL_RESET[cci_pkg::BIT_ON];
      neg_r    <= cci_pkg::FIELD2_ZERO;
      route_r  <= cci_pkg::FIELD2_ZERO;
      pol_r    <= cci_pkg::CTRL_RESET[cci_pkg::BIT_POL];
      speed_r  <= cci_pkg::FIELD2_ZERO;
      hyst_r   <= cci_pkg::CTRL_RESET[cci_pkg::BIT_HYST];
      rise_r   <= cci_pkg::CTRL_RESET[cci_pkg::BIT_RISE];
      fall_r   <= cci_pkg::CTRL_RESET[cci_pkg::BIT_FALL];
      irq_r    <= 1'h0;
      fabric_r <= 1'h0;
    end else begin
      on_r     <= on_nxt;
      neg_r    <= neg_nxt;
      route_r  <= route_nxt;
      pol_r    <= pol_nxt;
      speed_r  <= speed_nxt;
      hyst_r   <= hyst_nxt;
      rise_r   <= rise_nxt;
      fall_r   <= fall_nxt;
      irq_r    <= irq_nxt;
      fabric_r <= fabric_nxt;
    end
  end

  // analog-side controls straight from the stored fields
  assign comparator_on_o         = on_r;     // see [R2]
  assign negative_input_select_o = neg_r;    // see [R4]
  assign output_polarity_o       = pol_r;
  assign response_speed_o        = speed_r;  // see [R7]
  assign hysteresis_on_o         = hyst_r;   // see [R8]
  assign comp_out_o              = edg.level;
  assign fabric_out_o            = fabric_r;
  assign comp_irq_o              = irq_r;

endmodule : cci_comparator_ctrl

`default_nettype wire

// [rtl/cci_edge_det.sv]
`timescale 1ns/1ps
`default_nettype none

module cci_edge_det (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic raw_i,
  cci_edge_if.det   edg
);

  logic sync1_r, sync1_nxt;
  logic sync2_r, sync2_nxt;
  logic level_r, level_nxt;
  logic prev_r,  prev_nxt;

  // two-stage synchroniser, then polarity and enable gating
  always_comb begin
    sync1_nxt = raw_i;
    sync2_nxt = sync1_r;
    level_nxt = edg.enable & (sync2_r ^ edg.invert); // see [R6] [R12]
    prev_nxt  = level_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 1'h0;
      sync2_r <= 1'h0;
      level_r <= 1'h0;
      prev_r  <= 1'h0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      level_r <= level_nxt;
      prev_r  <= prev_nxt;
    end
  end

  // one-cycle edge pulses from the registered level
  assign edg.level = level_r;
  assign edg.rise  = level_r & ~prev_r;  // see [R9]
  assign edg.fall  = ~level_r & prev_r;  // see [R10]

endmodule : cci_edge_det

`default_nettype wire

// [rtl/cci_ifs.sv]
`timescale 1ns/1ps
`default_nettype none

// register access strobes between bus slave and core
interface cci_bus_if;
  logic                          wr_stb;
  logic [cci_pkg::ADR_W-1:0]     adr;
  logic [cci_pkg::DATA_W-1:0]    wdata;
  logic [cci_pkg::SEL_W-1:0]     sel;
  logic [cci_pkg::DATA_W-1:0]    rdata;

  modport slv  (output wr_stb, adr, wdata, sel, input rdata);
  modport core (input wr_stb, adr, wdata, sel, output rdata);
endinterface : cci_bus_if

// conditioned comparator level and its edges
interface cci_edge_if;
  logic enable;
  logic invert;
  logic level;
  logic rise;
  logic fall;

  modport det (input enable, invert, output level, rise, fall);
  modport ctl (output enable, invert, input level, rise, fall);
endinterface : cci_edge_if

`default_nettype wire

// [rtl/cci_pkg.sv]
package cci_pkg;

  // bus geometry
  localparam int DATA_W = 32;
  localparam int ADR_W  = 8;
  localparam int SEL_W  = DATA_W / 8;
  localparam int REG_W  = 16;

  // register byte offsets
  localparam logic [ADR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADR_W-1:0] STAT_OFS = 8'h04;

  // control register field positions
  localparam int BIT_ON      = 10;
  localparam int NEG_LO      = 8;
  localparam int ROUTE_LO    = 6;
  localparam int BIT_POL     = 5;
  localparam int SPEED_LO    = 3;
  localparam int BIT_HYST    = 2;
  localparam int BIT_RISE    = 1;
  localparam int BIT_FALL    = 0;
  localparam int FIELD2_W    = 2;

  // status register field positions
  localparam int STAT_LEVEL  = 0;

  // reset values
  localparam logic [REG_W-1:0]    CTRL_RESET  = 16'h0000;
  localparam logic [FIELD2_W-1:0] FIELD2_ZERO = 2'h0;

  // output route codes
  localparam logic [FIELD2_W-1:0] ROUTE_FABRIC = 2'h2;
  localparam logic [FIELD2_W-1:0] ROUTE_IRQ    = 2'h3;

  // bus slave states
  typedef enum logic {
    CCI_IDLE = 1'h0,
    CCI_ACK  = 1'h1
  } cci_wb_state_type;

endpackage : cci_pkg

// [rtl/cci_wb_slave.sv]
`timescale 1ns/1ps
`default_nettype none

module cci_wb_slave (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [cci_pkg::ADR_W-1:0]    wb_adr_i,
  input  wire logic [cci_pkg::SEL_W-1:0]    wb_sel_i,
  input  wire logic [cci_pkg::DATA_W-1:0]   wb_dat_i,
  output      logic [cci_pkg::DATA_W-1:0]   wb_dat_o,
  output      logic                         wb_ack_o,
  cci_bus_if.slv                            bus
);

  cci_pkg::cci_wb_state_type     state_r, state_nxt;
  logic [cci_pkg::DATA_W-1:0]    dat_r,   dat_nxt;
  logic                          req;

  assign req = wb_cyc_i & wb_stb_i;

  // one wait state; read data is latched with the ack so it stays stable
  always_comb begin
    state_nxt = state_r;
    dat_nxt   = dat_r;
    unique case (state_r)
      cci_pkg::CCI_IDLE: begin
        if (req) begin
          state_nxt = cci_pkg::CCI_ACK;
          dat_nxt   = bus.rdata;
        end
      end
      cci_pkg::CCI_ACK: begin
        state_nxt = cci_pkg::CCI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= cci_pkg::CCI_IDLE;
      dat_r   <= '0;
    end else begin
      state_r <= state_nxt;
      dat_r   <= dat_nxt;
    end
  end

  // write lands on the edge where the master sees ack
  assign wb_ack_o   = (state_r == cci_pkg::CCI_ACK);
  assign wb_dat_o   = dat_r;
  assign bus.wr_stb = wb_ack_o & req & wb_we_i;
  assign bus.adr    = wb_adr_i;
  assign bus.wdata  = wb_dat_i;
  assign bus.sel    = wb_sel_i;

endmodule : cci_wb_slave

`default_nettype wire

// [test/cci_comp_model.sv]
`timescale 1ns/1ps
`default_nettype none

module cci_comp_model (
  input  wire logic clk_i,
  input  wire logic level_i,
  input  wire logic slow_i,
  output wire logic raw_o
);
  logic [3:0] pipe_r;

  // analog settling: fast answers in one cycle, slow mode takes four
  initial begin
    pipe_r = 4'h0;
  end
  always @(posedge clk_i) begin
    pipe_r <= {pipe_r[2:0], level_i};
  end
  assign raw_o = slow_i ? pipe_r[3] : pipe_r[0];
endmodule : cci_comp_model

`default_nettype wire

// [test/cci_ctrl_props.sv]
`timescale 1ns/1ps
`default_nettype none

module cci_ctrl_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        comp_raw_i,
  input wire logic        comparator_on_o,
  input wire logic [1:0]  negative_input_select_o,
  input wire logic        output_polarity_o,
  input wire logic [1:0]  response_speed_o,
  input wire logic        hysteresis_on_o,
  input wire logic        comp_out_o,
  input wire logic        fabric_out_o,
  input wire logic        comp_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_ctrl;

  // write to the control register completing at this edge
  assign wr_ctrl = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & (wb_adr_i == cci_pkg::CTRL_OFS);

  sequence s_wr_hi; wr_ctrl && wb_sel_i[1]; endsequence
  sequence s_wr_lo; wr_ctrl && wb_sel_i[0]; endsequence
  sequence s_steady; (comparator_on_o && $stable(output_polarity_o)) [*4]; endsequence

  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i & wb_stb_i); endproperty
  property p_hi_zero;
    wb_ack_o && !wb_we_i && wb_adr_i == cci_pkg::CTRL_OFS |-> wb_dat_o[31:11] == 21'h0;
  endproperty
  property p_on;
    s_wr_hi |=> comparator_on_o == $past(wb_dat_i[10])
      && negative_input_select_o == $past(wb_dat_i[9:8]);
  endproperty
  property p_cfg;
    s_wr_lo |=> {output_polarity_o, response_speed_o, hysteresis_on_o} == $past(wb_dat_i[5:2]);
  endproperty
  // switching on must flag even with a quiet input
  property p_spur;
    wr_ctrl && wb_sel_i[1:0] == 2'h3 && !comparator_on_o && wb_dat_i[10]
      && wb_dat_i[7:6] == 2'h3 |-> ##[1:2] comp_irq_o;
  endproperty
  property p_level; s_steady |-> comp_out_o == ($past(comp_raw_i, 3) ^ output_polarity_o);
  endproperty
  property p_off; !comparator_on_o [*2] |-> !comp_out_o; endproperty
  property p_fabric; fabric_out_o |-> $past(comp_out_o); endproperty
  property p_route_off; s_wr_lo ##0 wb_dat_i[7:6] != 2'h3 |-> ##2 !comp_irq_o; endproperty

  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_hi_zero: assert property (p_hi_zero) else $error("reserved bits not zero");
  a_on: assert property (p_on) else $error("enable or input select wrong");
  a_cfg: assert property (p_cfg) else $error("low byte fields wrong");
  a_spur: assert property (p_spur) else $error("no interrupt on enable");
  a_level: assert property (p_level) else $error("output level wrong");
  a_off: assert property (p_off) else $error("output while off");
  a_fabric: assert property (p_fabric) else $error("fabric without level");
  a_route_off: assert property (p_route_off) else $error("irq on wrong route");
endmodule : cci_ctrl_props

bind cci_comparator_ctrl cci_ctrl_props cci_ctrl_props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comp_raw_i(comp_raw_i),
  .comparator_on_o(comparator_on_o), .negative_input_select_o(negative_input_select_o),
  .output_polarity_o(output_polarity_o), .response_speed_o(response_speed_o),
  .hysteresis_on_o(hysteresis_on_o), .comp_out_o(comp_out_o),
  .fabric_out_o(fabric_out_o), .comp_irq_o(comp_irq_o));

`default_nettype wire

// [test/tb_comparator_control_interface.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_comparator_control_interface;
  logic        clk_i, rst_i, cyc, stb, we, ack, lvl, slow, raw;
  logic        on, pol, hyst, cout, fab, irq;
  logic [1:0]  neg, spd;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rd;
  int          n_errors, cmp_count, cycles;

  cci_comparator_ctrl cci_comparator_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .comp_raw_i(raw),
    .comparator_on_o(on), .negative_input_select_o(neg), .output_polarity_o(pol),
    .response_speed_o(spd), .hysteresis_on_o(hyst), .comp_out_o(cout),
    .fabric_out_o(fab), .comp_irq_o(irq));
  cci_comp_model cci_comp_model_inst (.clk_i(clk_i), .level_i(lvl), .slow_i(slow), .raw_o(raw));

  task automatic give_verdict();
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one classic cycle, held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= {16'h0000, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : xfer

  task automatic rdchk(input string nm, input logic [15:0] exp);
    xfer(1'b0, 8'h00, 16'h0000, 4'hF);
    chk(nm, rd, {16'h0000, exp});
  endtask : rdchk

  task automatic s_reset();
    rdchk("ctrl reset", 16'h0000);
    xfer(1'b0, 8'h10, 16'h0000, 4'hF);
    chk("unmapped read", rd, 32'h0000_0000);
    chk("outputs", {on, neg, pol, spd, hyst, cout, fab, irq}, 32'h0);
  endtask : s_reset

  task automatic s_fields();
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {6'h00, 2'(i), 2'h0, i[0], 2'(i), i[1], 2'h0};
      xfer(1'b1, 8'h00, d, 4'h3);
      // fields settle on the edge the write lands; look one edge later
      @(posedge clk_i);
      chk("fields", {neg, pol, spd, hyst}, {26'h0, 2'(i), i[0], 2'(i), i[1]});
      rdchk("fields read", d);
    end
  endtask : s_fields

  task automatic s_flags();
    xfer(1'b1, 8'h00, 16'h04C0, 4'h3);
    rdchk("spurious", 16'h04C2);
    chk("spurious irq", irq, 1'b1);
    xfer(1'b1, 8'h00, 16'h04C2, 4'h3);
    rdchk("rise clear", 16'h04C0);
    lvl <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("level high", cout, 1'b1);
    xfer(1'b0, 8'h04, 16'h0000, 4'hF);
    chk("status level", rd, 32'h0000_0001);
    rdchk("rise set", 16'h04C2);
    xfer(1'b1, 8'h00, 16'h04C1, 4'h3);
    rdchk("zero keeps", 16'h04C2);
    lvl <= 1'b0;
    slow <= 1'b1;
    repeat (12) @(posedge clk_i);
    rdchk("fall set", 16'h04C3);
    xfer(1'b1, 8'h00, 16'h04C3, 4'h3);
    rdchk("both clear", 16'h04C0);
    chk("irq clear", irq, 1'b0);
  endtask : s_flags

  task automatic s_route();
    lvl <= 1'b1;
    slow <= 1'b0;
    repeat (10) @(posedge clk_i);
    xfer(1'b1, 8'h00, 16'h0483, 4'h3);
    repeat (2) @(posedge clk_i);
    chk("fabric route", {fab, irq}, 2'h2);
    xfer(1'b1, 8'h00, 16'h04A0, 4'h3);
    repeat (6) @(posedge clk_i);
    chk("inverted", {cout, fab, irq}, 3'h0);
    rdchk("polarity fall", 16'h04A1);
    xfer(1'b1, 8'h00, 16'h0060, 4'h3);
    repeat (3) @(posedge clk_i);
    chk("off", {on, cout}, 2'h0);
    // low lane only: route and polarity cleared, enable byte untouched
    xfer(1'b1, 8'h00, 16'h0400, 4'h1);
    xfer(1'b1, 8'h10, 16'hFFFF, 4'h3);
    rdchk("lanes and unmapped", 16'h0001);
  endtask : s_route

  // clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // hang guard, far above the roughly 150 cycles the run needs
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
    wdat = 32'h0; lvl = 1'b0; slow = 1'b0; n_errors = 0; cmp_count = 0; cycles = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_reset();
    s_fields();
    s_flags();
    s_route();
    give_verdict();
  end
endmodule : tb_comparator_control_interface

`default_nettype wire
